/* File: sim/ptpfs_props.sv */
// checker for the pin function select and write lock block
// assumes one strobe at a time on the register port
`timescale 1ns/10ps
module ptpfs_props (
  // clock and reset
  input wire        clock,
  input wire        reset_n,
  input wire        clkEn,
  // register port
  input wire [11:0] regAddr,
  input wire [31:0] regWrData,
  input wire        regWr,
  input wire        regRd,
  input wire [31:0] regRdData,
  // guarded writes
  input wire        sysWrReq,
  input wire [31:0] sysWrAddr,
  input wire        sysWrGo,
  input wire [31:0] sysWrBitEn,
  input wire        writeLockOn,
  // selections
  input wire [7:0]  port2GpioSel,
  input wire [7:0]  port2BusAddrSel,
  input wire [7:0]  port2PwmSel,
  input wire [7:0]  port2Reserved,
  input wire [7:0]  port4GpioSel,
  input wire        debugClockSel
);
  wire lockWr = clkEn && regWr && regAddr == 12'h100;
  wire sysGo  = clkEn && sysWrReq;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  lock_hold_a: assert property (
    !lockWr |=> $stable(writeLockOn)) else $error("lock moved");
  unlock_code_a: assert property (
    $fell(writeLockOn) |-> $past(lockWr && regWrData[7:0] == 8'h88))
    else $error("unlock without last code");
  relock_write_a: assert property (
    !writeLockOn && lockWr |=> writeLockOn) else $error("no relock");
  status_read_a: assert property (
    clkEn && regRd && regAddr == 12'h100 |=>
    regRdData == {31'h0, !$past(writeLockOn)}) else $error("bad status");
  guard_drop_a: assert property (
    sysGo && writeLockOn && sysWrAddr == 32'h5000_0008 |=>
    sysWrGo && sysWrBitEn == 32'h0) else $error("guarded write passed");
  power_flag_a: assert property (
    sysGo && writeLockOn && sysWrAddr == 32'h5000_0200 |=>
    sysWrBitEn == 32'h0000_0040) else $error("bad power mask");
  open_write_a: assert property (
    sysGo && !writeLockOn |=> sysWrGo && sysWrBitEn == 32'hFFFF_FFFF)
    else $error("unlocked write masked");
  port2_onehot_a: assert property (
    (port2GpioSel | port2BusAddrSel | port2PwmSel | port2Reserved) == 8'hFF
    && (port2GpioSel & (port2BusAddrSel | port2PwmSel)) == 8'h0)
    else $error("port 2 select overlap");
  port4_reset_a: assert property (
    $rose(reset_n) |-> port4GpioSel == 8'h3F && debugClockSel)
    else $error("port 4 reset wrong");
endmodule

bind ptpfs_pin_mux ptpfs_props u_props (
  .clock, .reset_n, .clkEn, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .sysWrReq, .sysWrAddr, .sysWrGo, .sysWrBitEn, .writeLockOn,
  .port2GpioSel, .port2BusAddrSel, .port2PwmSel, .port2Reserved,
  .port4GpioSel, .debugClockSel
);

/* File: sim/ptpfs_sys_peer.sv */
// system master and guarded register stand-in on the far side
// assumes the bench pulses kick for one cycle per write
`timescale 1ns/10ps
module ptpfs_sys_peer (
  // clock
  input  wire         clock,
  // bench request
  input  wire         kick,
  input  wire  [31:0] kickAddr,
  // guarded write side
  output logic        sysWrReq,
  output logic [31:0] sysWrAddr,
  input  wire         sysWrGo,
  input  wire  [31:0] sysWrBitEn,
  output logic [31:0] seenBitEn
);
  initial begin
    sysWrReq = 1'b0;
    sysWrAddr = 32'h0;
    seenBitEn = 32'h0;
  end
  always @(posedge clock) begin
    sysWrReq <= kick;
    // idle address toggles so a stale value never looks valid
    sysWrAddr <= kick ? kickAddr : ~sysWrAddr;
    if (sysWrGo)
      seenBitEn <= sysWrBitEn;
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench with a register model for pin select and lock
// assumes the design header path is on the include list
`timescale 1ns/10ps
module testbench;
  logic        clock = 1'b0, reset_n = 1'b0, clkEn = 1'b1;
  logic        regWr = 1'b0, regRd = 1'b0, kick = 1'b0;
  logic [11:0] regAddr = 12'h0;
  logic [31:0] regWrData = 32'h0, kickAddr = 32'h0, seed = 32'd25;
  logic [31:0] regRdData, sysWrAddr, sysWrBitEn, seen;
  logic        sysWrReq, sysWrGo, writeLockOn;
  logic [7:0]  port2GpioSel, port2BusAddrSel, port2PwmSel, port2Reserved,
    port2SchmittEn, port3GpioSel, port3Reserved, port3SchmittEn,
    port4GpioSel, port4Reserved, port4SchmittEn;
  logic        uart0RxSel, uart0TxSel, extInt0Sel, extInt1Sel, busClockSel,
    timer0PinSel, i2cDataSel, timer1PinSel, i2cClockSel, busWriteSel,
    clockDriverSel, busReadSel, busChipSelSel, busLatchSel, debugClockSel;
  logic [3:0]  port4PwmSel;
  logic [23:0] hold;
  logic [23:0] fn [3] = '{24'h0, 24'h0, 24'h0000C0};
  logic [31:0] gAddr [11] = '{32'h5000_0008, 32'h5000_0018, 32'h5000_0024,
    32'h5000_0200, 32'h5000_0208, 32'h5000_0210, 32'h5000_0214,
    32'h5000_C000, 32'h4000_4000, 32'h5000_C018, 32'h5000_0004};
  logic [31:0] gMask [11] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FFBF, 32'h1, 32'hFFFF_FFFF, 32'h3, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0};
  int          failures = 0, samples_checked = 0, unlocked = 0, step = 0;

  always #5 clock = ~clock;

  ptpfs_pin_mux u_dut (.clock, .reset_n, .clkEn, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .sysWrReq, .sysWrAddr, .sysWrGo,
    .sysWrBitEn, .writeLockOn, .port2GpioSel, .port2BusAddrSel,
    .port2PwmSel, .port2Reserved, .port2SchmittEn, .port3GpioSel,
    .uart0RxSel, .uart0TxSel, .extInt0Sel, .extInt1Sel, .busClockSel,
    .timer0PinSel, .i2cDataSel, .timer1PinSel, .i2cClockSel, .busWriteSel,
    .clockDriverSel, .busReadSel, .port3Reserved, .port3SchmittEn,
    .port4GpioSel, .port4PwmSel, .busChipSelSel, .busLatchSel,
    .debugClockSel, .port4Reserved, .port4SchmittEn);
  ptpfs_sys_peer u_peer (.clock, .kick, .kickAddr, .sysWrReq, .sysWrAddr,
    .sysWrGo, .sysWrBitEn, .seenBitEn(seen));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    regRd <= 1'b0;
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    if (a != 12'h100)
      step = 0;
    else if (unlocked != 0)
      unlocked = 0;
    else if (step == 0 && d[7:0] == 8'h59)
      step = 1;
    else if (step == 1 && d[7:0] == 8'h16)
      step = 2;
    else begin
      unlocked = (step == 2 && d[7:0] == 8'h88);
      step = 0;
    end
    if (a >= 12'h038 && a <= 12'h040)
      fn[(a - 12'h038) >> 2] = d[23:0];
  endtask
  task automatic rd(logic [11:0] a);
    logic [31:0] e;
    e = (a == 12'h100) ? unlocked : 32'h0;
    if (a >= 12'h038 && a <= 12'h040)
      e = {8'h0, fn[(a - 12'h038) >> 2]};
    regWr <= 1'b0;
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    check("read data", e, regRdData);
    @(posedge clock);
  endtask
  task automatic sysw(logic [31:0] a, logic [31:0] m);
    regWr <= 1'b0;
    kick <= 1'b1;
    kickAddr <= a;
    step = 0;
    @(posedge clock);
    kick <= 1'b0;
    repeat (4) @(posedge clock);
    check("bit enable", (unlocked != 0) ? 32'hFFFF_FFFF : ~m, seen);
  endtask
  task automatic decode();
    logic [7:0] a, m, u, v;
    regWr <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    a = fn[0][15:8];
    m = fn[0][7:0];
    check("p2 gpio", 8'(~(a | m)), port2GpioSel);
    check("p2 bus", m & ~a, port2BusAddrSel);
    check("p2 pwm", a & ~m, port2PwmSel);
    check("p2 none", a & m, port2Reserved);
    check("p2 schmitt", fn[0][23:16], port2SchmittEn);
    a = fn[1][15:8];
    m = fn[1][7:0];
    u = m & ~a;
    v = a & ~m;
    check("p3 gpio", 8'(~(a | m)), port3GpioSel);
    check("p3 none", a & (m | 8'h87), port3Reserved);
    check("p3 fn", {u[0], u[1], u[2], u[3], v[3], u[4], v[4], u[5], v[5],
      u[6], v[6], u[7]}, {uart0RxSel, uart0TxSel, extInt0Sel, extInt1Sel,
      busClockSel, timer0PinSel, i2cDataSel, timer1PinSel, i2cClockSel,
      busWriteSel, clockDriverSel, busReadSel});
    check("p3 schmitt", fn[1][23:16], port3SchmittEn);
    a = fn[2][15:8];
    m = fn[2][7:0];
    u = m & ~a;
    check("p4 gpio", 8'(~(a | m)), port4GpioSel);
    check("p4 none", a, port4Reserved);
    check("p4 fn", u[6:0], {debugClockSel, busLatchSel, busChipSelSel,
      port4PwmSel});
    check("p4 schmitt", fn[2][23:16], port4SchmittEn);
  endtask
  task automatic codes(logic [39:0] c, int n);
    for (int i = n - 1; i >= 0; i--)
      wr(12'h100, {24'h0, c[i * 8 +: 8]});
    regWr <= 1'b0;
    @(posedge clock);
    check("lock", (unlocked != 0) ? 32'h0 : 32'h1, writeLockOn);
    rd(12'h100);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    failures++;
    results();
  end
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check("lock", 32'h1, writeLockOn);
    decode();
    for (int i = 0; i < 5; i++)
      rd(12'h038 + 12'(4 * i) + ((i == 4) ? 12'h0BC : 12'h0));
    repeat (40) begin
      seed = xs(seed);
      wr(12'h038 + 12'(4 * (seed % 3)), seed);
      decode();
      rd(12'h038 + 12'(4 * (seed % 3)));
    end
    hold = fn[0];
    clkEn <= 1'b0;
    wr(12'h038, ~seed);
    clkEn <= 1'b1;
    fn[0] = hold;
    rd(12'h038);
    wr(12'h044, seed);
    rd(12'h044);
    for (int i = 0; i < 11; i++)
      sysw(gAddr[i], gMask[i]);
    codes(40'h591688, 3);
    for (int i = 0; i < 11; i++)
      sysw(gAddr[i], gMask[i]);
    codes(40'h5A, 1);
    codes(40'h598816, 3);
    codes(40'h591788, 3);
    codes(40'h5916591688, 5);
    codes(40'h5916, 2);
    wr(12'h038, seed);
    codes(40'h88, 1);
    codes(40'h5916, 2);
    sysw(gAddr[3], gMask[3]);
    codes(40'h88, 1);
    codes(40'h59, 1);
    codes(40'h16, 1);
    codes(40'h88, 1);
    codes(40'h00, 1);
    results();
  end
endmodule

/* File: verilog/ptpfs_map.vh */
// register map, field positions, reset values and codes of the pin
// function select and write lock block
// assumes byte addressing on a 12-bit register port, 32-bit data
`ifndef PTPFS_MAP_VH
`define PTPFS_MAP_VH

// register port
`define PTPFS_ADDR_W        12
`define PTPFS_DATA_W        32

// register offsets
`define PTPFS_OFS_PORT2     12'h038
`define PTPFS_OFS_PORT3     12'h03C
`define PTPFS_OFS_PORT4     12'h040
`define PTPFS_OFS_UNLOCK    12'h100

// function register fields
`define PTPFS_MULTI_LSB     0
`define PTPFS_MULTI_MSB     7
`define PTPFS_ALT_LSB       8
`define PTPFS_ALT_MSB       15
`define PTPFS_SCHMITT_LSB   16
`define PTPFS_SCHMITT_MSB   23
`define PTPFS_FN_W          24

// reset values, stored 24-bit part only
`define PTPFS_RST_PORT2     24'h000000
`define PTPFS_RST_PORT3     24'h000000
`define PTPFS_RST_PORT4     24'h0000C0

// unlock register
`define PTPFS_CODE_LSB      0
`define PTPFS_CODE_MSB      7
`define PTPFS_DIS_BIT       0
`define PTPFS_CODE_FIRST    8'h59
`define PTPFS_CODE_SECOND   8'h16
`define PTPFS_CODE_THIRD    8'h88

// guarded system registers, full addresses
`define PTPFS_GA_RESET_CTL  32'h5000_0008
`define PTPFS_GA_BROWNOUT   32'h5000_0018
`define PTPFS_GA_POR_CTL    32'h5000_0024
`define PTPFS_GA_POWER_CTL  32'h5000_0200
`define PTPFS_GA_PCLK_EN    32'h5000_0208
`define PTPFS_GA_CLK_SEL0   32'h5000_0210
`define PTPFS_GA_CLOCK_SELECT_ONE   32'h5000_0214
`define PTPFS_GA_FLASH_PRG  32'h5000_C000
`define PTPFS_GA_WATCHDOG   32'h4000_4000
`define PTPFS_GA_FLASH_ACC  32'h5000_C018

// guarded bits inside each register: all, part or none
`define PTPFS_GM_ALL        32'hFFFF_FFFF
`define PTPFS_GM_POWER_CTL  32'hFFFF_FFBF
`define PTPFS_GM_PCLK_EN    32'h0000_0001
`define PTPFS_GM_CLOCK_SELECT_ONE   32'h0000_0003
`define PTPFS_GM_NONE       32'h0000_0000

// unlock sequencer states
`define PTPFS_ST_IDLE       2'h0
`define PTPFS_ST_FIRST      2'h1
`define PTPFS_ST_SECOND     2'h2

`endif

/* File: verilog/ptpfs_pin_mux.v */
// pin function select for ports 2, 3, 4 plus the write lock sequencer
// assumes one clock, synchronous inputs, a register port with read data
// one cycle after the read strobe, and a system write port to filter
`timescale 1ns/10ps
`include "ptpfs_map.vh"

module ptpfs_pin_mux (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  input  wire        clkEn,
  // register port
  input  wire [11:0] regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdData,
  // system write port to the guarded registers
  input  wire        sysWrReq,
  input  wire [31:0] sysWrAddr,
  output reg         sysWrGo,
  output reg  [31:0] sysWrBitEn,
  output reg         writeLockOn,
  // port 2 selections
  output reg  [7:0]  port2GpioSel,
  output reg  [7:0]  port2BusAddrSel,
  output reg  [7:0]  port2PwmSel,
  output reg  [7:0]  port2Reserved,
  output reg  [7:0]  port2SchmittEn,
  // port 3 selections
  output reg  [7:0]  port3GpioSel,
  output reg         uart0RxSel,
  output reg         uart0TxSel,
  output reg         extInt0Sel,
  output reg         extInt1Sel,
  output reg         busClockSel,
  output reg         timer0PinSel,
  output reg         i2cDataSel,
  output reg         timer1PinSel,
  output reg         i2cClockSel,
  output reg         busWriteSel,
  output reg         clockDriverSel,
  output reg         busReadSel,
  output reg  [7:0]  port3Reserved,
  output reg  [7:0]  port3SchmittEn,
  // port 4 selections
  output reg  [7:0]  port4GpioSel,
  output reg  [3:0]  port4PwmSel,
  output reg         busChipSelSel,
  output reg         busLatchSel,
  output reg         debugClockSel,
  output reg  [7:0]  port4Reserved,
  output reg  [7:0]  port4SchmittEn
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // pin pair code: {alternate, multi}
  function [1:0] pinCode;
    input [23:0] fn;
    input [2:0]  pin;
    begin
      pinCode = {fn[`PTPFS_ALT_LSB + pin], fn[`PTPFS_MULTI_LSB + pin]};
    end
  endfunction

  // guarded bits of a system address, zero when not guarded
  function [31:0] guardMask;
    input [31:0] addr;
    begin
      case (addr)
        `PTPFS_GA_RESET_CTL: guardMask = `PTPFS_GM_ALL;
        `PTPFS_GA_BROWNOUT:  guardMask = `PTPFS_GM_ALL;
        `PTPFS_GA_POR_CTL:   guardMask = `PTPFS_GM_ALL;
        `PTPFS_GA_POWER_CTL: guardMask = `PTPFS_GM_POWER_CTL;
        `PTPFS_GA_PCLK_EN:   guardMask = `PTPFS_GM_PCLK_EN;
        `PTPFS_GA_CLK_SEL0:  guardMask = `PTPFS_GM_ALL;
        `PTPFS_GA_CLOCK_SELECT_ONE:  guardMask = `PTPFS_GM_CLOCK_SELECT_ONE;
        `PTPFS_GA_FLASH_PRG: guardMask = `PTPFS_GM_ALL;
        `PTPFS_GA_WATCHDOG:  guardMask = `PTPFS_GM_ALL;
        `PTPFS_GA_FLASH_ACC: guardMask = `PTPFS_GM_ALL;
        default:             guardMask = `PTPFS_GM_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register file

  // unlock sequencer steps, one per code byte already taken
  localparam [1:0] SEQ_IDLE   = `PTPFS_ST_IDLE;
  localparam [1:0] SEQ_FIRST  = `PTPFS_ST_FIRST;
  localparam [1:0] SEQ_SECOND = `PTPFS_ST_SECOND;

  // only bits 23:0 are stored; bits 31:24 read back as zero
  reg  [23:0] port2Fn_q;
  reg  [23:0] port3Fn_q;
  reg  [23:0] port4Fn_q;
  reg         unlocked_q;
  reg  [1:0]  seqState_q;
  reg  [1:0]  seqState_d;
  reg         unlocked_d;
  reg  [31:0] rdData_d;

  wire        wrPort2  = regWr && (regAddr == `PTPFS_OFS_PORT2);
  wire        wrPort3  = regWr && (regAddr == `PTPFS_OFS_PORT3);
  wire        wrPort4  = regWr && (regAddr == `PTPFS_OFS_PORT4);
  wire        wrUnlock = regWr && (regAddr == `PTPFS_OFS_UNLOCK);
  wire [7:0]  codeByte = regWrData[`PTPFS_CODE_MSB:`PTPFS_CODE_LSB];

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port2Fn_q <= `PTPFS_RST_PORT2;
      port3Fn_q <= `PTPFS_RST_PORT3;
      port4Fn_q <= `PTPFS_RST_PORT4;
    end else if (clkEn) begin
      if (wrPort2) begin
        port2Fn_q <= regWrData[23:0];
      end
      if (wrPort3) begin
        port3Fn_q <= regWrData[23:0];
      end
      if (wrPort4) begin
        port4Fn_q <= regWrData[23:0];
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always @* begin
    rdData_d = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        `PTPFS_OFS_PORT2:  rdData_d = {8'h00, port2Fn_q};
        `PTPFS_OFS_PORT3:  rdData_d = {8'h00, port3Fn_q};
        `PTPFS_OFS_PORT4:  rdData_d = {8'h00, port4Fn_q};
        `PTPFS_OFS_UNLOCK: rdData_d = {31'h0, unlocked_q};
        default:           rdData_d = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdData <= rdData_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unlock sequencer

  // a write anywhere else, on either port, breaks the sequence
  // reads do not count as writes, so status polls between codes are safe
  wire otherWrite = (regWr && !wrUnlock) || sysWrReq;

  // a wrong byte drops to idle and is not taken as a new first code
  always @* begin
    seqState_d = seqState_q;
    unlocked_d = unlocked_q;
    if (unlocked_q) begin
      seqState_d = SEQ_IDLE;
      if (wrUnlock) begin
        unlocked_d = 1'b0;
      end
    end else if (otherWrite) begin
      seqState_d = SEQ_IDLE;
    end else if (wrUnlock) begin
      case (seqState_q)
        SEQ_IDLE: begin
          if (codeByte == `PTPFS_CODE_FIRST) begin
            seqState_d = SEQ_FIRST;
          end
        end
        SEQ_FIRST: begin
          if (codeByte == `PTPFS_CODE_SECOND) begin
            seqState_d = SEQ_SECOND;
          end else begin
            seqState_d = SEQ_IDLE;
          end
        end
        SEQ_SECOND: begin
          seqState_d = SEQ_IDLE;
          if (codeByte == `PTPFS_CODE_THIRD) begin
            unlocked_d = 1'b1;
          end
        end
        default: begin
          seqState_d = SEQ_IDLE;
        end
      endcase
    end
  end

  // lock state and step freeze together with clkEn
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      seqState_q <= SEQ_IDLE;
      unlocked_q <= 1'b0;
    end else if (clkEn) begin
      seqState_q <= seqState_d;
      unlocked_q <= unlocked_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // guarded write filter

  // filter uses the registered lock, so a write beside the last code
  // byte is still treated as locked
  wire [31:0] sysGuard = guardMask(sysWrAddr);

  // lock output mirrors the next lock state, so it lines up with
  // the filter decision of the following cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sysWrGo     <= 1'b0;
      sysWrBitEn  <= 32'h0000_0000;
      writeLockOn <= 1'b1;
    end else if (clkEn) begin
      sysWrGo     <= sysWrReq;
      writeLockOn <= !unlocked_d;
      if (!sysWrReq) begin
        sysWrBitEn <= 32'h0000_0000;
      end else if (unlocked_q) begin
        sysWrBitEn <= `PTPFS_GM_ALL;
      end else begin
        sysWrBitEn <= ~sysGuard;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin function decode

  reg [7:0] p2Gpio_d;
  reg [7:0] p2Bus_d;
  reg [7:0] p2Pwm_d;
  reg [7:0] p2Res_d;
  reg [7:0] p3Gpio_d;
  reg [7:0] p3Res_d;
  reg [7:0] p4Gpio_d;
  reg [7:0] p4Res_d;
  reg [1:0] code;
  integer   i;

  always @* begin
    p2Gpio_d = 8'h00;
    p2Bus_d  = 8'h00;
    p2Pwm_d  = 8'h00;
    p2Res_d  = 8'h00;
    p3Gpio_d = 8'h00;
    p3Res_d  = 8'h00;
    p4Gpio_d = 8'h00;
    p4Res_d  = 8'h00;
    code     = 2'h0;
    for (i = 0; i < 8; i = i + 1) begin
      code = pinCode(port2Fn_q, i[2:0]);
      p2Gpio_d[i] = (code == 2'h0);
      p2Bus_d[i]  = (code == 2'h1);
      p2Pwm_d[i]  = (code == 2'h2);
      p2Res_d[i]  = (code == 2'h3);
      code = pinCode(port3Fn_q, i[2:0]);
      p3Gpio_d[i] = (code == 2'h0);
      // pins 3, 4, 5, 6 use all three codes, others reserve alternate
      if (i == 4 || i == 5 || i == 6) begin
        p3Res_d[i] = (code == 2'h3);
      end else if (i == 3) begin
        p3Res_d[i] = (code == 2'h3);
      end else begin
        p3Res_d[i] = code[1];
      end
      code = pinCode(port4Fn_q, i[2:0]);
      p4Gpio_d[i] = (code == 2'h0);
      p4Res_d[i]  = code[1];
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port2GpioSel    <= 8'hFF;
      port2BusAddrSel <= 8'h00;
      port2PwmSel     <= 8'h00;
      port2Reserved   <= 8'h00;
      port2SchmittEn  <= 8'h00;
      port3GpioSel    <= 8'hFF;
      uart0RxSel      <= 1'b0;
      uart0TxSel      <= 1'b0;
      extInt0Sel      <= 1'b0;
      extInt1Sel      <= 1'b0;
      busClockSel     <= 1'b0;
      timer0PinSel    <= 1'b0;
      i2cDataSel      <= 1'b0;
      timer1PinSel    <= 1'b0;
      i2cClockSel     <= 1'b0;
      busWriteSel     <= 1'b0;
      clockDriverSel  <= 1'b0;
      busReadSel      <= 1'b0;
      port3Reserved   <= 8'h00;
      port3SchmittEn  <= 8'h00;
      port4GpioSel    <= 8'h3F;
      port4PwmSel     <= 4'h0;
      busChipSelSel   <= 1'b0;
      busLatchSel     <= 1'b0;
      debugClockSel   <= 1'b1;
      port4Reserved   <= 8'h00;
      port4SchmittEn  <= 8'h00;
    end else if (clkEn) begin
      port2GpioSel    <= p2Gpio_d;
      port2BusAddrSel <= p2Bus_d;
      port2PwmSel     <= p2Pwm_d;
      port2Reserved   <= p2Res_d;
      port2SchmittEn  <= port2Fn_q[23:16];
      port3GpioSel    <= p3Gpio_d;
      uart0RxSel      <= (pinCode(port3Fn_q, 3'd0) == 2'h1);
      uart0TxSel      <= (pinCode(port3Fn_q, 3'd1) == 2'h1);
      extInt0Sel      <= (pinCode(port3Fn_q, 3'd2) == 2'h1);
      extInt1Sel      <= (pinCode(port3Fn_q, 3'd3) == 2'h1);
      busClockSel     <= (pinCode(port3Fn_q, 3'd3) == 2'h2);
      timer0PinSel    <= (pinCode(port3Fn_q, 3'd4) == 2'h1);
      i2cDataSel      <= (pinCode(port3Fn_q, 3'd4) == 2'h2);
      timer1PinSel    <= (pinCode(port3Fn_q, 3'd5) == 2'h1);
      i2cClockSel     <= (pinCode(port3Fn_q, 3'd5) == 2'h2);
      busWriteSel     <= (pinCode(port3Fn_q, 3'd6) == 2'h1);
      clockDriverSel  <= (pinCode(port3Fn_q, 3'd6) == 2'h2);
      busReadSel      <= (pinCode(port3Fn_q, 3'd7) == 2'h1);
      port3Reserved   <= p3Res_d;
      port3SchmittEn  <= port3Fn_q[23:16];
      port4GpioSel    <= p4Gpio_d;
      port4PwmSel     <= port4Fn_q[3:0] & ~port4Fn_q[11:8];
      busChipSelSel   <= (pinCode(port4Fn_q, 3'd4) == 2'h1);
      busLatchSel     <= (pinCode(port4Fn_q, 3'd5) == 2'h1);
      debugClockSel   <= (pinCode(port4Fn_q, 3'd6) == 2'h1);
      port4Reserved   <= p4Res_d;
      port4SchmittEn  <= port4Fn_q[23:16];
    end
  end

endmodule
